// File: compare_capture_pwm_timer.sv
// Purpose: Compare/capture/PWM timer, 16-bit or wide 32-bit form, AXI4-Lite registers
// Assumes: Event inputs come from outside the clock domain
// Notes: WIDE picks the 32-bit form; FIRST_INSTANCE enables dead-time
// Functional notes
// - Standard form: 16-bit counter, four capture/compare channels.
// - Wide form behaves the same with 32-bit counter and channel values.
// - Each channel is off or runs in exactly one of capture, compare or PWM.
// - Capture copies the counter into the channel value register on the selected event.
// - Compare output follows counter against the programmed threshold.
// - PWM duty follows successive written compare values, reloaded at wrap.
// - Dead-time between complementary PWM outputs exists only in the first instance.
// - Counter can count events; triggers go out to the event network.
`timescale 1ns/1ns
`include "timer_map.svh"
module compare_capture_pwm_timer #(
  parameter bit WIDE = 1'b0,
  parameter bit FIRST_INSTANCE = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`TMR_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`TMR_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [`TMR_CH_N-1:0] evt_in,
  output logic [`TMR_CH_N-1:0] ch_out,
  output logic [`TMR_CH_N-1:0] ch_out_n,
  output logic [`TMR_TRIG_W-1:0] trig_out
);
  function automatic logic [31:0] trim(input logic [31:0] x);
    trim = WIDE ? x : (x & `TMR_NARROW_MASK);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        merge[b*8 +: 8] = n[b*8 +: 8];
  endfunction

  logic [`TMR_CH_N-1:0] sy1_q, sy2_q, sy3_q, edge_w;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d, awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [`TMR_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] ctrl_q, ctrl_d, status_q, status_d, cnt_q, cnt_d, top_q, top_d;
  logic [31:0] dtime_q, dtime_d;
  timer_pkg::cc_cfg_t cfg_q [`TMR_CH_N], cfg_d [`TMR_CH_N];
  logic [31:0] val_q [`TMR_CH_N], val_d [`TMR_CH_N], buf_q [`TMR_CH_N], buf_d [`TMR_CH_N];
  logic [`TMR_DT_W-1:0] dtc_q [`TMR_CH_N], dtc_d [`TMR_CH_N];
  logic [`TMR_CH_N-1:0] raw_q, raw_d, out_q, out_d, outn_q, outn_d;
  logic [`TMR_TRIG_W-1:0] trig_q, trig_d;
  logic tick, wrap;

  // Edge detect reads only the second and third stages
  assign edge_w = sy2_q & ~sy3_q;

  always_comb
  begin
    logic [31:0] set, clr, rd;
    logic [5:0] widx, ridx;
    logic raw, dead, ev;
    int ch;
    set = '0;
    clr = '0;
    rd = '0;
    widx = awaddr_q[7:2];
    ridx = araddr[7:2];
    raw = 1'b0;
    dead = 1'b0;
    ev = 1'b0;
    ch = 0;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    cnt_d = cnt_q;
    top_d = top_q;
    dtime_d = dtime_q;
    cfg_d = cfg_q;
    val_d = val_q;
    buf_d = buf_q;
    dtc_d = dtc_q;
    raw_d = raw_q;
    out_d = '0;
    outn_d = '0;
    trig_d = '0;
    // Counter: free running or counting edges of event line 0
    tick = ctrl_q[`TMR_CTRL_RUN] & (ctrl_q[`TMR_CTRL_EVCOUNT] ? edge_w[0] : 1'b1);
    wrap = tick & (cnt_q == trim(top_q));
    if (tick)
      cnt_d = wrap ? '0 : trim(32'(cnt_q + 32'h1));
    if (wrap)
    begin
      set[`TMR_ST_OVF] = 1'b1;
      trig_d[0] = 1'b1;
    end
    for (int i = 0; i < `TMR_CH_N; i++)
    begin
      ev = edge_w[cfg_q[i].evsel];
      dead = FIRST_INSTANCE & dtime_q[`TMR_DT_EN] & (cfg_q[i].mode == timer_pkg::MODE_PWM);
      unique case (cfg_q[i].mode)
        timer_pkg::MODE_CAPTURE:
        begin
          raw = 1'b0;
          if (ev)
          begin
            val_d[i] = cnt_q;
            set[`TMR_ST_CAP0 + i] = 1'b1;
            trig_d[i+1] = 1'b1;
          end
        end
        timer_pkg::MODE_COMPARE:
        begin
          raw = (cnt_q >= val_q[i]);
          trig_d[i+1] = tick & (cnt_q == val_q[i]);
        end
        timer_pkg::MODE_PWM:
        begin
          raw = (cnt_q < val_q[i]);
          if (wrap)
            val_d[i] = buf_q[i];
          trig_d[i+1] = wrap;
        end
        timer_pkg::MODE_OFF:
          raw = 1'b0;
      endcase
      raw_d[i] = raw;
      // Both legs stay low while the gap runs, so the driver never shoots through
      if (dead && raw != raw_q[i])
        dtc_d[i] = dtime_q[`TMR_DT_W-1:0];
      else if (dtc_q[i] != '0)
        dtc_d[i] = dtc_q[i] - 8'h01;
      outn_d[i] = (cfg_q[i].mode != timer_pkg::MODE_OFF) & ~raw & (dtc_d[i] == '0);
      out_d[i] = (cfg_q[i].mode != timer_pkg::MODE_OFF) & raw & (dtc_d[i] == '0);
    end
    // Write channel: address and data taken in either order
    if (awvalid && awready_q)
    begin
      aw_got_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready_q)
    begin
      w_got_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    if (aw_got_q && w_got_q && !bvalid_q)
    begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `TMR_RESP_OKAY;
      if (widx == `TMR_IDX_CTRL)
        ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
      else if (widx == `TMR_IDX_STATUS)
        clr = merge('0, wdata_q, wstrb_q);
      else if (widx == `TMR_IDX_COUNT)
        cnt_d = trim(merge(cnt_q, wdata_q, wstrb_q));
      else if (widx == `TMR_IDX_TOP)
        top_d = trim(merge(top_q, wdata_q, wstrb_q));
      else if (widx == `TMR_IDX_DTIME)
        dtime_d = FIRST_INSTANCE ? merge(dtime_q, wdata_q, wstrb_q) : '0;
      else if (widx >= `TMR_IDX_CC_FIRST && widx <= `TMR_IDX_CC_LAST)
      begin
        ch = int'(widx[2:1]);
        if (!widx[0])
          cfg_d[ch] = timer_pkg::cc_cfg_t'(wstrb_q[0] ? wdata_q[3:0] : cfg_q[ch]);
        else
        begin
          buf_d[ch] = trim(merge(buf_q[ch], wdata_q, wstrb_q));
          if (cfg_q[ch].mode != timer_pkg::MODE_PWM)
            val_d[ch] = trim(merge(val_q[ch], wdata_q, wstrb_q));
        end
      end
      else
        bresp_d = `TMR_RESP_SLVERR;
    end
    // Set wins over a clear in the same cycle
    status_d = (status_q & ~clr) | set;
    // Read channel: one cycle from address to data
    if (rvalid_q && rready)
      rvalid_d = 1'b0;
    if (arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = `TMR_RESP_OKAY;
      if (ridx == `TMR_IDX_CTRL)
        rd = ctrl_q;
      else if (ridx == `TMR_IDX_STATUS)
        rd = status_q;
      else if (ridx == `TMR_IDX_COUNT)
        rd = cnt_q;
      else if (ridx == `TMR_IDX_TOP)
        rd = top_q;
      else if (ridx == `TMR_IDX_DTIME)
        rd = dtime_q;
      else if (ridx >= `TMR_IDX_CC_FIRST && ridx <= `TMR_IDX_CC_LAST)
        rd = ridx[0] ? val_q[ridx[2:1]] : {28'h0, cfg_q[ridx[2:1]]};
      else
        rresp_d = `TMR_RESP_SLVERR;
      rdata_d = rd;
    end
    awready_d = ~aw_got_d & ~bvalid_d;
    wready_d = ~w_got_d & ~bvalid_d;
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    sy1_q <= evt_in;
    sy2_q <= sy1_q;
    sy3_q <= sy2_q;
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `TMR_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `TMR_RESP_OKAY;
      rdata_q <= '0;
      ctrl_q <= '0;
      status_q <= '0;
      cnt_q <= '0;
      // Narrow form must read back only its 16 ones after reset
      top_q <= trim(`TMR_RST_TOP);
      dtime_q <= '0;
      for (int i = 0; i < `TMR_CH_N; i++)
      begin
        cfg_q[i] <= '0;
        val_q[i] <= '0;
        buf_q[i] <= '0;
        dtc_q[i] <= '0;
      end
      raw_q <= '0;
      out_q <= '0;
      outn_q <= '0;
      trig_q <= '0;
    end
    else
    begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      status_q <= status_d;
      cnt_q <= cnt_d;
      top_q <= top_d;
      dtime_q <= dtime_d;
      cfg_q <= cfg_d;
      val_q <= val_d;
      buf_q <= buf_d;
      dtc_q <= dtc_d;
      raw_q <= raw_d;
      out_q <= out_d;
      outn_q <= outn_d;
      trig_q <= trig_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign ch_out = out_q;
  assign ch_out_n = outn_q;
  assign trig_out = trig_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence cap0_event;
    cfg_q[0].mode == timer_pkg::MODE_CAPTURE && edge_w[cfg_q[0].evsel];
  endsequence

  a_narrow_counter_width: assert property (!WIDE |-> cnt_q[31:16] == 16'h0)
    else $error("Narrow counter has upper bits set");
  a_count_step_one: assert property (tick && !wrap && !(aw_got_q && w_got_q && !bvalid_q)
    |=> cnt_q == trim(32'($past(cnt_q) + 32'h1)))
    else $error("Counter did not advance by one");
  a_mode_gates_out: assert property (cfg_q[0].mode == timer_pkg::MODE_OFF
    |=> !out_q[0] && !outn_q[0])
    else $error("Idle channel drives an output");
  a_capture_copies_count: assert property (cap0_event |=> val_q[0] == $past(cnt_q)
    && status_q[`TMR_ST_CAP0])
    else $error("Capture missed the counter value");
  a_compare_out_level: assert property (cfg_q[1].mode == timer_pkg::MODE_COMPARE
    |=> out_q[1] == ($past(cnt_q) >= $past(val_q[1])))
    else $error("Compare output wrong");
  a_pwm_reload_wrap: assert property (cfg_q[2].mode == timer_pkg::MODE_PWM && wrap
    |=> val_q[2] == $past(buf_q[2]))
    else $error("PWM duty not reloaded at wrap");
  a_deadtime_absent: assert property (!FIRST_INSTANCE |-> dtime_q == 32'h0)
    else $error("Dead-time present in later instance");
  a_wrap_trigger_flag: assert property (trig_out[0] == $past(wrap))
    else $error("Wrap trigger missing");
  a_overflow_sticky: assert property (wrap |=> status_q[`TMR_ST_OVF])
    else $error("Overflow flag not set");
  // Must stay live while reset is low, so the default disable is overridden
  a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0) !aresetn
    |=> cnt_q == 32'h0 && out_q == '0 && outn_q == '0)
    else $error("Reset left counter or outputs active");
endmodule

// File: event_source_model.sv
// Purpose: Far-side model: event sources on pins and network, trigger observer
// Assumes: One clock shared with the timer
// Notes: Events last 4 cycles so the two-flop input sync cannot miss one
`timescale 1ns/1ns
module event_source_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] fire,
  input wire logic [4:0] trig_out,
  output logic [3:0] evt_in = 4'h0,
  output logic [15:0] wraps = 16'h0
);
  logic [2:0] hold_q = 3'h0;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      evt_in <= 4'h0;
      hold_q <= 3'h0;
      wraps <= 16'h0;
    end
    else
    begin
      if (fire != 4'h0)
      begin
        evt_in <= fire;
        hold_q <= 3'h4;
      end
      else if (hold_q != 3'h0)
        hold_q <= hold_q - 3'h1;
      if (fire == 4'h0 && hold_q == 3'h1)
        evt_in <= 4'h0;
      if (trig_out[0])
        wraps <= wraps + 16'h1;
    end
  end
endmodule

// File: test_compare_capture_pwm_timer.sv
// Purpose: Self-checking bench for registers and channel behaviour
// Assumes: Standard 16-bit form, plus a wide first instance mirroring the same bus
// Notes: Expected values come from the register map alone
`timescale 1ns/1ns
module test_compare_capture_pwm_timer;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [3:0] fire = 4'h0;
  logic [3:0] evt_in;
  logic [3:0] ch_out;
  logic [3:0] ch_out_n;
  logic [3:0] ch_out_w;
  logic [31:0] rdata_w, rdw;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, lr;
  logic [4:0] trig_out;
  logic [15:0] wraps;
  int mismatches = 0;
  int checks_done = 0;
  int ones;
  int ones_w;
  compare_capture_pwm_timer dut_u (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .evt_in(evt_in), .ch_out(ch_out), .ch_out_n(ch_out_n),
    .trig_out(trig_out));
  event_source_model far_u (.aclk(aclk), .aresetn(aresetn), .fire(fire),
    .trig_out(trig_out), .evt_in(evt_in), .wraps(wraps));
  // Bus logic does not depend on the parameters, so this copy answers in step
  compare_capture_pwm_timer #(.WIDE(1'b1), .FIRST_INSTANCE(1'b1)) wide_u (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(rdata_w), .rresp(),
    .rvalid(), .rready(rready), .evt_in(evt_in), .ch_out(ch_out_w), .ch_out_n(),
    .trig_out());
  always #2 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Signals read right after an edge still hold their pre-edge values
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
      lr = bresp;
    end
    while (!bvalid);
    bready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
      rd = rdata;
      rdw = rdata_w;
      lr = rresp;
    end
    while (!rvalid);
    rready <= 1'h0;
    chk(rd, exp);
  endtask
  task automatic ev();
    @(posedge aclk);
    fire <= 4'h1;
    @(posedge aclk);
    fire <= 4'h0;
    repeat (10) @(posedge aclk);
  endtask
  // One full PWM period of 16 counts
  task automatic cnt(input int b);
    ones = 0;
    ones_w = 0;
    repeat (16)
    begin
      @(posedge aclk);
      ones += int'(ch_out[b] === 1'h1);
      ones_w += int'(ch_out_w[b] === 1'h1);
    end
  endtask
  task automatic give_verdict;
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // About 350 cycles expected; over fifteen times that is a hang
  initial
  begin
    repeat (6000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk({28'h0, ch_out}, 32'h0);
    rc(8'h00, 32'h0);
    rc(8'h08, 32'h0);
    rc(8'h0C, 32'h0000FFFF);
    chk(rdw, 32'hFFFFFFFF);
    rc(8'h20, 32'h0);
    rc(8'h14, 32'h0);
    chk({30'h0, lr}, 32'h2);
    wr(8'h18, 32'h5);
    chk({30'h0, lr}, 32'h2);
    wr(8'h0C, 32'hFFFFFFFF);
    rc(8'h0C, 32'h0000FFFF);
    chk(rdw, 32'hFFFFFFFF);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h38, 32'(m));
      rc(8'h38, 32'(m));
    end
    // Dead-time of two cycles, enabled; only the wide first instance keeps it
    wr(8'h10, 32'h102);
    rc(8'h10, 32'h0);
    chk(rdw, 32'h102);
    wr(8'h20, 32'h1);
    wr(8'h08, 32'h1234);
    ev();
    rc(8'h24, 32'h1234);
    chk(rdw, 32'h1234);
    rc(8'h04, 32'h10);
    wr(8'h04, 32'h10);
    rc(8'h04, 32'h0);
    wr(8'h28, 32'h2);
    wr(8'h2C, 32'h10);
    wr(8'h08, 32'h0F);
    repeat (3) @(posedge aclk);
    chk({30'h0, ch_out[1], ch_out_n[1]}, 32'h1);
    wr(8'h08, 32'h10);
    repeat (3) @(posedge aclk);
    chk({30'h0, ch_out[1], ch_out_n[1]}, 32'h2);
    wr(8'h30, 32'h3);
    wr(8'h34, 32'h8);
    wr(8'h0C, 32'hF);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    repeat (40) @(posedge aclk);
    cnt(2);
    chk(32'(ones), 32'h8);
    chk(32'(ones_w), 32'h6);
    wr(8'h34, 32'h4);
    repeat (40) @(posedge aclk);
    cnt(2);
    chk(32'(ones), 32'h4);
    chk(32'(ones_w), 32'h2);
    chk({31'h0, wraps != 16'h0}, 32'h1);
    wr(8'h00, 32'h0);
    rc(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    rc(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'hFFFF);
    wr(8'h00, 32'h3);
    ev();
    ev();
    ev();
    wr(8'h00, 32'h0);
    rc(8'h08, 32'h3);
    // Reset again with channels programmed and channel 2 output high
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk({28'h0, ch_out}, 32'h0);
    rc(8'h08, 32'h0);
    rc(8'h30, 32'h0);
    rc(8'h34, 32'h0);
    rc(8'h0C, 32'h0000FFFF);
    chk(rdw, 32'hFFFFFFFF);
    give_verdict();
  end
endmodule

// File: timer_map.svh
// Purpose: Register offsets, field positions, reset values and widths of the timer
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes: Channel registers sit in pairs, control then value
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
`define TMR_ADDR_W 8
`define TMR_IDX_CTRL 6'h00
`define TMR_IDX_STATUS 6'h01
`define TMR_IDX_COUNT 6'h02
`define TMR_IDX_TOP 6'h03
`define TMR_IDX_DTIME 6'h04
`define TMR_IDX_CC_FIRST 6'h08
`define TMR_IDX_CC_LAST 6'h0F
`define TMR_CTRL_RUN 0
`define TMR_CTRL_EVCOUNT 1
`define TMR_ST_OVF 0
`define TMR_ST_CAP0 4
`define TMR_DT_EN 8
`define TMR_DT_W 8
`define TMR_CH_N 4
`define TMR_TRIG_W 5
`define TMR_RST_TOP 32'hFFFFFFFF
`define TMR_NARROW_MASK 32'h0000FFFF
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2
`endif

// File: timer_pkg.sv
// Purpose: Types shared by the timer design
// Assumes: Nothing beyond the map header
// Notes: Channel configuration travels as one packed struct
package timer_pkg;
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_COMPARE = 2'b10,
    MODE_PWM = 2'b11
  } cc_mode_t;
  typedef struct packed {
    logic [1:0] evsel;
    cc_mode_t mode;
  } cc_cfg_t;
endpackage
